/* File: core/gauge_i2c_defs.vh */
// Constants for the gauge I2C target port: address, command map limits,
// control subcommands and timing figures.
// Assumes a 10 MHz system clock; times are converted to cycles in the modules.
`ifndef GAUGE_I2C_DEFS_VH
`define GAUGE_I2C_DEFS_VH

// =====================================================================
// Bus address and command space
`define TARGET_ADDR 7'h55
`define CMD_MAX 8'h6B
`define CMD_RESET_PTR 8'h00
`define CTRL_LOW_CMD 8'h00
`define CTRL_HIGH_CMD 8'h01
`define RO_FIRST_CMD 8'h02

// =====================================================================
// Control subcommands
`define ENTER_DEEP_HIB_SUBCMD 16'h0011
`define LEAVE_DEEP_HIB_SUBCMD 16'h0012
`define ENTER_LIGHT_DOZE_SUBCMD 16'h0013
`define LEAVE_LIGHT_DOZE_SUBCMD 16'h0014

// =====================================================================
// Control status bit positions
`define CTL_DEEP_HIB_BIT 15
`define CTL_LIGHT_DOZE_BIT 13

// =====================================================================
// Power mode codes
`define MODE_NORMAL 3'h0
`define MODE_LIGHT_DOZE 3'h1
`define MODE_SLEEP 3'h2
`define MODE_DEEP_HIB 3'h3
`define MODE_NO_BATTERY 3'h4

// =====================================================================
// Timing figures
`define CLK_HZ 10000000
`define BUS_LOW_TIMEOUT_S 2
`define WAKE_STRETCH_US 4000
`define FLASH_WRITE_MS 72
`define FLASH_RESTORE_MS 116

`endif

/* File: core/gauge_power_ctrl.v */
// Power mode sequencer of the gauge: chooses among five modes and drives
// the oscillator enables and the wake-up stretch request.
// Assumes all inputs are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "gauge_i2c_defs.vh"

module gauge_power_ctrl #(
  parameter WAKE_CYCLES = (`WAKE_STRETCH_US * (`CLK_HZ / 1000000))
) (
  input wire clk,
  input wire rst_n,
  input wire batteryPresent,
  input wire deepHibRequest,
  input wire lightDozeRequest,
  input wire idleRequest,
  input wire busActivity,
  input wire pinActivity,
  input wire timeoutSleep,
  output reg [2:0] powerMode,
  output wire lfOscEnable,
  output wire hfOscEnable,
  output wire wakeBusy
);
  reg [2:0] mode_next;
  reg [23:0] wakeCnt_reg;

  // =====================================================================
  // Mode selection
  always @* begin
    mode_next = powerMode;
    if (!batteryPresent) begin
      mode_next = `MODE_NO_BATTERY; // [R22]
    end else if (busActivity || pinActivity) begin
      mode_next = `MODE_NORMAL; // [R21]
    end else if (timeoutSleep) begin
      mode_next = `MODE_SLEEP; // [R9]
    end else if (idleRequest) begin
      if (deepHibRequest) begin
        mode_next = `MODE_DEEP_HIB; // [R18]
      end else if (lightDozeRequest) begin
        mode_next = `MODE_LIGHT_DOZE; // [R18]
      end else begin
        mode_next = `MODE_SLEEP; // [R18]
      end
    end else if (powerMode == `MODE_NO_BATTERY) begin
      mode_next = `MODE_NORMAL;
    end
  end

  // Mode register and wake-up counter
  always @(posedge clk) begin
    if (!rst_n) begin
      powerMode <= `MODE_NORMAL;
      wakeCnt_reg <= 24'h000000;
    end else begin
      powerMode <= mode_next;
      if ((powerMode == `MODE_LIGHT_DOZE || powerMode == `MODE_DEEP_HIB)
          && busActivity) begin
        wakeCnt_reg <= WAKE_CYCLES[23:0]; // [R14]
      end else if (wakeCnt_reg != 24'h000000) begin
        wakeCnt_reg <= wakeCnt_reg - 24'h000001;
      end
    end
  end

  // Oscillator enables: doze keeps both, sleep and hibernation stop the fast one
  assign lfOscEnable = 1'b1; // [R19]
  assign hfOscEnable = (powerMode == `MODE_NORMAL) || (powerMode == `MODE_LIGHT_DOZE)
                       || (powerMode == `MODE_NO_BATTERY); // [R19] [R20]
  assign wakeBusy = (wakeCnt_reg != 24'h000000);
endmodule // gauge_power_ctrl

`default_nettype wire

/* File: core/gauge_i2c_target_port.v */
// I2C target port of a single-cell gauge: address match, command pointer,
// read and write forms, NACK of bad accesses, bus-low timeout, clock
// stretching and power mode control.
// Assumes open-drain pads outside; enables are active low (low = drive low).
`timescale 1ns/10ps
`default_nettype none
`include "gauge_i2c_defs.vh"

// Summary of operation
// R1: Answer only target address 1010101, first byte 0xAA write, 0xAB read.
// R2: Support plain, incremental, quick reads and single, incremental writes.
// R3: Quick read returns byte at current command pointer without a command byte.
// R4: Pointer advances by one whenever a data byte is acknowledged by anyone.
// R5: Writes without new command byte use the same pointer auto-increment.
// R6: Data written to a read-only location is not acknowledged.
// R7: Command byte above 0x6B is not acknowledged.
// R8: Bus held low two seconds releases both data and clock lines.
// R9: If a line stays low after release, enter low-power sleep.
// R10: Host leaves bus free at least 66 us between packets.
// R11: Above 100 kHz host uses single-byte writes only.
// R12: Host waits two seconds after read-write command before reading result.
// R13: Host issues standard commands at most twice per second.
// R14: In doze and hibernation stretch clock at start of all traffic, up to 4 ms.
// R15: In normal and no-battery modes stretch only packets addressed here.
// R16: Flow-control stretch after start, acknowledge or first data bit; code stretches only after acknowledge and first read data bit.
// R17: Stretch about 72 ms for flash write, 116 ms for restore.
// R18: Move among five power modes by events; host may request some.
// R19: Light doze keeps low and high frequency oscillators running.
// R20: Sleep stops high frequency oscillator, still measures periodically.
// R21: Deep hibernation wakes on bus traffic or pin activity.
// R22: Stay in no-battery wait mode while no battery is inserted.
// R23: Subcommand 0x0011 sets, 0x0012 clears deep-hibernation request bit.
// R24: Subcommand 0x0013 sets, 0x0014 clears light-doze request bit.
// R25: Timeout counter restarts whenever both lines are seen high.
module gauge_i2c_target_port #(
  parameter TIMEOUT_CYCLES = `BUS_LOW_TIMEOUT_S * `CLK_HZ,
  parameter FLASH_WRITE_CYCLES = `FLASH_WRITE_MS * (`CLK_HZ / 1000),
  parameter FLASH_RESTORE_CYCLES = `FLASH_RESTORE_MS * (`CLK_HZ / 1000),
  parameter RO_LAST_CMD = 8'h3F
) (
  input wire clk,
  input wire rst_n,
  input wire sclIn,
  output wire sclOut,
  output wire sclOe_n,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe_n,
  input wire [7:0] readData,
  output reg [7:0] cmdPointer,
  output reg [7:0] writeData,
  output reg writeStrobe,
  output reg [15:0] controlStatus,
  input wire batteryPresent,
  input wire idleRequest,
  input wire pinActivity,
  input wire flashWriteStart,
  input wire flashRestoreStart,
  output wire [2:0] powerMode,
  output wire lfOscEnable,
  output wire hfOscEnable
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_ACK = 3'h5;
  localparam ST_RACK = 3'h6;

  reg [1:0] sclSync_reg;
  reg [1:0] sdaSync_reg;
  reg sclPrev_reg;
  reg sdaPrev_reg;
  reg [2:0] state_reg;
  reg [2:0] afterAck_reg;
  reg [3:0] bitCnt_reg;
  reg [7:0] shift_reg;
  reg rnw_reg;
  reg ackDrive_reg;
  reg addressed_reg;
  reg [7:0] subLow_reg;
  reg [31:0] lowCnt_reg;
  reg released_reg;
  reg timeoutSleep_reg;
  reg [23:0] stretchCnt_reg;
  reg flowStretch_reg;
  wire scl;
  wire sda;
  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  wire wakeBusy;
  wire stretch;
  wire drivesLow;

  // =====================================================================
  // Pin synchronisers and edge detection on the second stage
  always @(posedge clk) begin
    if (!rst_n) begin
      sclSync_reg <= 2'h3;
      sdaSync_reg <= 2'h3;
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclSync_reg <= {sclSync_reg[0], sclIn};
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclPrev_reg <= sclSync_reg[1];
      sdaPrev_reg <= sdaSync_reg[1];
    end
  end

  assign scl = sclSync_reg[1];
  assign sda = sdaSync_reg[1];
  assign sclRise = scl && !sclPrev_reg;
  assign sclFall = !scl && sclPrev_reg;
  assign startCond = scl && sclPrev_reg && !sda && sdaPrev_reg;
  assign stopCond = scl && sclPrev_reg && sda && !sdaPrev_reg;

  // =====================================================================
  // Protocol engine
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      afterAck_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rnw_reg <= 1'b0;
      ackDrive_reg <= 1'b0;
      addressed_reg <= 1'b0;
      cmdPointer <= `CMD_RESET_PTR;
      writeData <= 8'h00;
      writeStrobe <= 1'b0;
      controlStatus <= 16'h0000;
      subLow_reg <= 8'h00;
    end else begin
      writeStrobe <= 1'b0;
      if (released_reg) begin
        state_reg <= ST_IDLE; // [R8]
        ackDrive_reg <= 1'b0;
        addressed_reg <= 1'b0;
      end else if (startCond) begin
        state_reg <= ST_ADDR;
        bitCnt_reg <= 4'h0;
        ackDrive_reg <= 1'b0;
        addressed_reg <= 1'b0;
      end else if (stopCond) begin
        state_reg <= ST_IDLE;
        ackDrive_reg <= 1'b0;
        addressed_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (sclRise) begin
              shift_reg <= {shift_reg[6:0], sda};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall && bitCnt_reg == 4'h8) begin
              bitCnt_reg <= 4'h0;
              state_reg <= ST_ACK;
              ackDrive_reg <= 1'b0;
              afterAck_reg <= ST_IDLE;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == `TARGET_ADDR) begin // [R1]
                  ackDrive_reg <= 1'b1;
                  addressed_reg <= 1'b1;
                  rnw_reg <= shift_reg[0];
                  // Read with no command byte serves the current pointer [R3]
                  afterAck_reg <= shift_reg[0] ? ST_RDATA : ST_CMD; // [R2]
                end
              end else if (state_reg == ST_CMD) begin
                if (shift_reg <= `CMD_MAX) begin // [R7]
                  ackDrive_reg <= 1'b1;
                  cmdPointer <= shift_reg;
                  afterAck_reg <= ST_WDATA;
                end
              end else begin
                if (cmdPointer >= `RO_FIRST_CMD && cmdPointer <= RO_LAST_CMD) begin
                  afterAck_reg <= ST_IDLE; // [R6]
                end else begin
                  ackDrive_reg <= 1'b1;
                  writeData <= shift_reg;
                  writeStrobe <= 1'b1;
                  cmdPointer <= cmdPointer + 8'h01; // [R4] [R5]
                  afterAck_reg <= ST_WDATA;
                  if (cmdPointer == `CTRL_LOW_CMD) begin
                    subLow_reg <= shift_reg;
                  end else if (cmdPointer == `CTRL_HIGH_CMD) begin
                    case ({shift_reg, subLow_reg})
                      `ENTER_DEEP_HIB_SUBCMD: controlStatus[`CTL_DEEP_HIB_BIT] <= 1'b1; // [R23]
                      `LEAVE_DEEP_HIB_SUBCMD: controlStatus[`CTL_DEEP_HIB_BIT] <= 1'b0; // [R23]
                      `ENTER_LIGHT_DOZE_SUBCMD: controlStatus[`CTL_LIGHT_DOZE_BIT] <= 1'b1; // [R24]
                      `LEAVE_LIGHT_DOZE_SUBCMD: controlStatus[`CTL_LIGHT_DOZE_BIT] <= 1'b0; // [R24]
                      default: controlStatus <= controlStatus;
                    endcase
                  end
                end
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              ackDrive_reg <= 1'b0;
              state_reg <= afterAck_reg;
              if (afterAck_reg == ST_RDATA) begin
                shift_reg <= readData;
              end
            end
          end
          ST_RDATA: begin
            if (sclFall) begin
              if (bitCnt_reg == 4'h7) begin
                bitCnt_reg <= 4'h0;
                state_reg <= ST_RACK;
              end else begin
                bitCnt_reg <= bitCnt_reg + 4'h1;
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              if (!sda) begin
                cmdPointer <= cmdPointer + 8'h01; // [R4]
                afterAck_reg <= ST_RDATA;
              end else begin
                afterAck_reg <= ST_IDLE;
              end
            end else if (sclFall) begin
              state_reg <= afterAck_reg;
              if (afterAck_reg == ST_RDATA) begin
                shift_reg <= readData;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // =====================================================================
  // Bus-low timeout and release
  always @(posedge clk) begin
    if (!rst_n) begin
      lowCnt_reg <= 32'h00000000;
      released_reg <= 1'b0;
      timeoutSleep_reg <= 1'b0;
    end else begin
      timeoutSleep_reg <= 1'b0;
      if (scl && sda) begin
        lowCnt_reg <= 32'h00000000; // [R25]
        released_reg <= 1'b0;
      end else if (lowCnt_reg >= TIMEOUT_CYCLES[31:0] - 32'h00000001) begin
        released_reg <= 1'b1; // [R8]
        timeoutSleep_reg <= released_reg; // [R9]
      end else begin
        lowCnt_reg <= lowCnt_reg + 32'h00000001;
      end
    end
  end

  // =====================================================================
  // Clock stretch sources: flow control, flash writes and flash restores
  always @(posedge clk) begin
    if (!rst_n) begin
      stretchCnt_reg <= 24'h000000;
      flowStretch_reg <= 1'b0;
    end else begin
      // One cycle hold after an ack or the first read data bit, once addressed [R16]
      flowStretch_reg <= addressed_reg && sclFall &&
                         (state_reg == ST_ACK || state_reg == ST_RACK ||
                          (state_reg == ST_RDATA && bitCnt_reg == 4'h0));
      if (flashRestoreStart) begin
        stretchCnt_reg <= FLASH_RESTORE_CYCLES[23:0]; // [R17]
      end else if (flashWriteStart) begin
        stretchCnt_reg <= FLASH_WRITE_CYCLES[23:0]; // [R17]
      end else if (stretchCnt_reg != 24'h000000) begin
        stretchCnt_reg <= stretchCnt_reg - 24'h000001;
      end
    end
  end

  // Wake stretch applies to any traffic; others only when addressed [R14] [R15]
  assign stretch = !released_reg && (wakeBusy ||
                   (addressed_reg && (flowStretch_reg || stretchCnt_reg != 24'h000000)));
  assign sclOut = 1'b0;
  assign sclOe_n = !(stretch && !scl);
  assign drivesLow = !released_reg &&
                     ((state_reg == ST_ACK && ackDrive_reg) ||
                      (state_reg == ST_RDATA && !shift_reg[7]));
  assign sdaOut = 1'b0;
  assign sdaOe_n = !drivesLow;

  // =====================================================================
  // Power modes
  gauge_power_ctrl u_power (
    .clk(clk),
    .rst_n(rst_n),
    .batteryPresent(batteryPresent),
    .deepHibRequest(controlStatus[`CTL_DEEP_HIB_BIT]),
    .lightDozeRequest(controlStatus[`CTL_LIGHT_DOZE_BIT]),
    .idleRequest(idleRequest),
    .busActivity(startCond),
    .pinActivity(pinActivity),
    .timeoutSleep(timeoutSleep_reg),
    .powerMode(powerMode),
    .lfOscEnable(lfOscEnable),
    .hfOscEnable(hfOscEnable),
    .wakeBusy(wakeBusy)
  );
endmodule // gauge_i2c_target_port

`default_nettype wire

/* File: tb/gauge_i2c_port_sva.sv */
// Property checker for the gauge target port, bound onto its ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "gauge_i2c_defs.vh"

module gauge_i2c_port_sva #(
  parameter TIMEOUT_CYCLES = 20000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sclOe_n,
  input wire logic sdaOe_n,
  input wire logic writeStrobe,
  input wire logic [7:0] cmdPointer,
  input wire logic [15:0] controlStatus,
  input wire logic batteryPresent,
  input wire logic [2:0] powerMode,
  input wire logic lfOscEnable,
  input wire logic hfOscEnable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  int lowCount;
  int stretchCount;
  int strobeAge;

  // =====================================================================
  // Helper counters: bus-low time, stretch length, age of last write
  always @(posedge clk) begin
    if (!rst_n) begin
      lowCount <= 0;
      stretchCount <= 0;
      strobeAge <= 255;
    end else begin
      lowCount <= (sclIn && sdaIn) ? 0 : lowCount + 1;
      stretchCount <= sclOe_n ? 0 : stretchCount + 1;
      strobeAge <= writeStrobe ? 0 : ((strobeAge < 255) ? strobeAge + 1 : 255);
    end
  end

  // =====================================================================
  // Sequences and properties
  sequence busIdle;
    (sclIn && sdaIn) [*6];
  endsequence

  sequence noBattery;
    !batteryPresent [*2];
  endsequence

  a_ptr_idle: assert property (busIdle |-> $stable(cmdPointer))
    else $error("pointer moved while bus idle");
  a_strobe_single: assert property (writeStrobe |=> !writeStrobe)
    else $error("write strobe longer than one cycle");
  a_timeout_release: assert property (lowCount >= TIMEOUT_CYCLES + 4 |-> sclOe_n && sdaOe_n)
    else $error("lines still driven after bus-low timeout");
  a_timeout_sleep: assert property (lowCount == TIMEOUT_CYCLES + 6 |-> powerMode == `MODE_SLEEP)
    else $error("no sleep after timeout with line held low");
  a_stretch_bound: assert property (stretchCount <= 40100)
    else $error("clock stretch too long");
  a_doze_osc: assert property (powerMode == `MODE_LIGHT_DOZE |-> hfOscEnable && lfOscEnable)
    else $error("oscillator off in light doze");
  a_sleep_hf_off: assert property (powerMode inside {`MODE_SLEEP, `MODE_DEEP_HIB} |-> !hfOscEnable)
    else $error("fast oscillator on in low power mode");
  a_no_batt_mode: assert property (noBattery |=> powerMode == `MODE_NO_BATTERY)
    else $error("not in no-battery wait without battery");
  a_ctl_on_write: assert property ($changed(controlStatus) |-> writeStrobe || strobeAge <= 4)
    else $error("control status changed without a write");
endmodule // gauge_i2c_port_sva
`default_nettype wire

/* File: tb/i2c_host_model.sv */
// Host bus controller model: drives clock and data open-drain, bit by bit.
// Assumes the bench resolves each wire from all parties' pull-downs.
`timescale 1ns/10ps
`default_nettype none

module i2c_host_model #(
  parameter int PH = 34
) (
  input wire logic clk,
  input wire logic sclLine,
  input wire logic sdaLine,
  output logic sclRel,
  output logic sdaRel,
  output logic hung
);
  // Bus starts released
  initial begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
    hung = 1'b0;
  end

  // One phase of the bus clock
  task automatic half();
    repeat (PH) @(negedge clk);
  endtask

  // Releases the clock and waits out any stretch, bounded
  task automatic sclHigh();
    int n;
    n = 0;
    sclRel = 1'b1;
    while (sclLine !== 1'b1 && n < 50000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50000) hung = 1'b1;
  endtask

  // Data set while the clock is low, sampled mid-high
  task automatic bitXfer(input logic b, output logic s);
    sdaRel = b;
    half();
    sclHigh();
    repeat (PH / 2) @(negedge clk);
    s = sdaLine;
    repeat (PH / 2) @(negedge clk);
    sclRel = 1'b0;
    half();
  endtask

  // Start or repeated start
  task automatic start();
    sdaRel = 1'b1;
    half();
    sclHigh();
    half();
    sdaRel = 1'b0;
    half();
    sclRel = 1'b0;
    half();
  endtask

  // Stop, then bus-free time before the next packet
  task automatic stop();
    sdaRel = 1'b0;
    half();
    sclHigh();
    half();
    sdaRel = 1'b1;
    repeat (700) @(negedge clk);
  endtask

  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitXfer(d[i], s);
    bitXfer(1'b1, s);
    ack = ~s;
  endtask

  task automatic readByte(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitXfer(1'b1, s);
      d[i] = s;
    end
    bitXfer(~ack, s);
  endtask
endmodule // i2c_host_model
`default_nettype wire

/* File: tb/gauge_i2c_target_port_tb_top.sv */
// Bench top for the gauge target port: host model, scenarios, verdict.
// Assumes the design, defines header, checker and host model are compiled.
`timescale 1ns/10ps
`default_nettype none
`include "gauge_i2c_defs.vh"

module gauge_i2c_target_port_tb_top;
  localparam int TIMEOUT = 6000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic batteryPresent = 1'b1;
  logic flashWriteStart = 1'b0;
  logic idleRequest = 1'b0;
  int mismatches = 0;
  int samples_checked = 0;
  int stretchCycles = 0;
  wire sclOut, sclOe_n, sdaOut, sdaOe_n, writeStrobe, lfOscEnable, hfOscEnable;
  wire sclRel, sdaRel, hung;
  wire [7:0] cmdPointer, writeData;
  wire [15:0] controlStatus;
  wire [2:0] powerMode;
  // =====================================================================
  // Wired-AND bus lines and the gauge's read data
  wire sclLine = sclRel & (sclOe_n | sclOut);
  wire sdaLine = sdaRel & (sdaOe_n | sdaOut);
  wire [7:0] readData = cmdPointer ^ 8'h3C;

  always #50 clk = ~clk;
  // Counts cycles the target holds the clock low
  always @(posedge clk) if (!sclOe_n) stretchCycles++;

  gauge_i2c_target_port #(.TIMEOUT_CYCLES(TIMEOUT), .FLASH_WRITE_CYCLES(3000),
    .FLASH_RESTORE_CYCLES(3000)) i_dut (.clk(clk), .rst_n(rst_n), .sclIn(sclLine),
    .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .readData(readData), .cmdPointer(cmdPointer), .writeData(writeData),
    .writeStrobe(writeStrobe), .controlStatus(controlStatus), .batteryPresent(batteryPresent),
    .idleRequest(idleRequest), .pinActivity(1'b0), .flashWriteStart(flashWriteStart),
    .flashRestoreStart(1'b0), .powerMode(powerMode), .lfOscEnable(lfOscEnable),
    .hfOscEnable(hfOscEnable));

  i2c_host_model i_host (.clk(clk), .sclLine(sclLine), .sdaLine(sdaLine), .sclRel(sclRel),
    .sdaRel(sdaRel), .hung(hung));

  // =====================================================================
  // Shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [7:0] d, input logic expAck);
    logic ack;
    i_host.writeByte(d, ack);
    check(16'(ack), 16'(expAck));
  endtask

  task automatic rb(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    i_host.readByte(d, ack);
    check(16'(d), 16'(exp));
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic flash_pulse();
    @(negedge clk);
    flashWriteStart = 1'b1;
    @(negedge clk);
    flashWriteStart = 1'b0;
    stretchCycles = 0;
  endtask

  task automatic tally_and_finish();
    check(16'(hung), 16'h0000);
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_write();
    i_host.start();
    wb(8'hAA, 1'b1);
    wb(8'h40, 1'b1);
    check(16'(cmdPointer), 16'h0040);
    wb(8'h5A, 1'b1);
    check(16'(writeData), 16'h005A);
    wb(8'hA5, 1'b1);
    check(16'(writeData), 16'h00A5);
    check(16'(cmdPointer), 16'h0042);
    i_host.stop();
    $display("write test done");
  endtask

  task automatic t_read();
    i_host.start();
    wb(8'hAA, 1'b1);
    wb(8'h50, 1'b1);
    i_host.start();
    wb(8'hAB, 1'b1);
    rb(1'b1, 8'h50 ^ 8'h3C);
    rb(1'b0, 8'h51 ^ 8'h3C);
    i_host.stop();
    check(16'(cmdPointer), 16'h0051);
    i_host.start();
    wb(8'hAB, 1'b1);
    rb(1'b0, 8'h51 ^ 8'h3C);
    i_host.stop();
    $display("read test done");
  endtask

  task automatic t_refuse();
    i_host.start();
    wb(8'hAA, 1'b1);
    wb(8'h6C, 1'b0);
    i_host.stop();
    i_host.start();
    wb(8'hAA, 1'b1);
    wb(8'h02, 1'b1);
    wb(8'h77, 1'b0);
    i_host.stop();
    check(16'(cmdPointer), 16'h0002);
    check(16'(writeData), 16'h00A5);
    i_host.start();
    wb(8'hA8, 1'b0);
    i_host.stop();
    $display("refusal test done");
  endtask

  task automatic t_flash();
    flash_pulse();
    i_host.start();
    wb(8'hAA, 1'b1);
    wb(8'h6B, 1'b1);
    wb(8'h33, 1'b1);
    i_host.stop();
    check(16'(stretchCycles >= 500), 16'h0001);
    flash_pulse();
    i_host.start();
    wb(8'hA8, 1'b0);
    i_host.stop();
    check(16'(stretchCycles), 16'h0000);
    $display("stretch test done");
  endtask

  // Results are taken at the port; command pacing has no model here
  task automatic t_subcmd();
    logic [7:0] code [4] = '{8'h13, 8'h14, 8'h11, 8'h12};
    logic [15:0] expSt [4] = '{16'h2000, 16'h0000, 16'h8000, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      i_host.start();
      wb(8'hAA, 1'b1);
      wb(8'h00, 1'b1);
      wb(code[i], 1'b1);
      wb(8'h00, 1'b1);
      i_host.stop();
      check(controlStatus, expSt[i]);
    end
    $display("subcommand test done");
  endtask

  // Low-power entry by subcommand and idle request, then a START wakes it
  task automatic t_wake(input logic [7:0] code, input logic [2:0] mode, input logic hf);
    i_host.start();
    wb(8'hAA, 1'b1);
    wb(8'h00, 1'b1);
    wb(code, 1'b1);
    wb(8'h00, 1'b1);
    i_host.stop();
    @(negedge clk);
    idleRequest = 1'b1;
    @(negedge clk);
    idleRequest = 1'b0;
    check(16'(powerMode), 16'(mode));
    check(16'(hfOscEnable), 16'(hf));
    i_host.start();
    check(16'(sclOe_n), 16'h0000);
    check(16'(powerMode), 16'(`MODE_NORMAL));
    do_reset();
    i_host.stop();
    $display("wake test done");
  endtask

  task automatic t_nobatt();
    batteryPresent = 1'b0;
    do_reset();
    check(16'(powerMode), 16'(`MODE_NO_BATTERY));
    batteryPresent = 1'b1;
    do_reset();
    $display("no battery test done");
  endtask

  // Target drives a zero data bit while the host parks the clock low
  task automatic t_timeout();
    do_reset();
    i_host.start();
    wb(8'hAB, 1'b1);
    repeat (TIMEOUT + 20) @(negedge clk);
    check(16'({sclOe_n, sdaOe_n, sdaLine}), 16'h0007);
    check(16'(powerMode), 16'(`MODE_SLEEP));
    check(16'(hfOscEnable), 16'h0000);
    i_host.sclRel = 1'b1;
    do_reset();
    $display("timeout test done");
  endtask

  // =====================================================================
  // Main sequence and watchdog
  initial begin
    do_reset();
    t_write();
    t_read();
    t_refuse();
    t_flash();
    t_subcmd();
    t_wake(8'h13, `MODE_LIGHT_DOZE, 1'b1);
    t_wake(8'h11, `MODE_DEEP_HIB, 1'b0);
    t_nobatt();
    t_timeout();
    tally_and_finish();
  end

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule // gauge_i2c_target_port_tb_top

bind gauge_i2c_target_port gauge_i2c_port_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_sva (
  .clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sclOe_n(sclOe_n),
  .sdaOe_n(sdaOe_n), .writeStrobe(writeStrobe), .cmdPointer(cmdPointer),
  .controlStatus(controlStatus), .batteryPresent(batteryPresent), .powerMode(powerMode),
  .lfOscEnable(lfOscEnable), .hfOscEnable(hfOscEnable));
`default_nettype wire
